// >>> hdl/dat_demod_backend.sv
// dat_demod_backend: frequency error loop, post-demodulation filter and
// bit decision of the receiver, with its register file on the serial port
// assumes: demodulator samples and receive-state flags arrive on mclk;
// serial port pins are asynchronous to mclk and sampled by it
//
// Functional notes
// (RULE_01) frequency error is a read-only 8-bit signed register
// (RULE_02) error LSB scales with crystal over two to IF+filter+14
// (RULE_03) error magnitude is clamped to sixteen times the max-offset field
// (RULE_04) correction restarts whenever host or polled receive becomes active
// (RULE_05) FSK host receive with freeze set holds correction after preamble
// (RULE_06) freeze has no effect while modulation select is ASK
// (RULE_07) software uses freeze and loop gain 3 for alternating preambles
// (RULE_08) software uses correction only with Manchester data in FSK
// (RULE_09) software derives Manchester rate from divider fields, numerator 4
// (RULE_10) software uses numerator 8 for NRZ rate
// (RULE_11) bandwidth select zero gives narrower filter, one gives full rate
// (RULE_12) transmitted rate stays between 0.6 and 1.03 of recommended
// (RULE_13) filter output compared with threshold drives the data pin
// (RULE_14) FSK threshold is fixed at zero
// (RULE_15) ASK threshold adapts using low-pass or peak detector method
// (RULE_16) software picks low-pass for Manchester, peak detect for NRZ
// (RULE_17) threshold bandwidth bit affects only the low-pass method
// (RULE_18) discharge time field affects only the peak detector
// (RULE_19) peak time constant field affects only the peak detector
// (RULE_20) software sets threshold gain from IF and filter selects
// (RULE_21) signed floor field bounds the ASK threshold from below
// (RULE_22) software calibrates floor from filter samples in host receive
// (RULE_23) threshold type zero picks low-pass, one picks peak detector
// (RULE_24) max-offset zero keeps synthesizer fixed, correction disabled
// (RULE_25) readout registers ignore writes without disturbing loop or filter
`timescale 1ns/1ns
`default_nettype none

module dat_demod_backend (
    // clock and reset
    input  wire  logic       mclk,
    input  wire  logic       rst,
    // serial port pins
    input  wire  logic       spiClk,
    input  wire  logic       spiSelN,
    input  wire  logic       spiMosi,
    output var   logic       spiMisoOut,
    output var   logic       spiMisoOe,
    // receiver state
    input  wire  logic       hostRxActive,
    input  wire  logic       polledRxActive,
    input  wire  logic       preambleDetect,
    // demodulator samples
    input  wire  logic       freqErrValid,
    input  wire  logic [7:0] freqErrSample,
    input  wire  logic       demodValid,
    input  wire  logic [7:0] demodSample,
    // results
    output var   logic [7:0] freqCorrOut,
    output var   logic       correctionFrozen,
    output var   logic       dataOut
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic signed [7:0] max8(input logic signed [7:0] a,
                                               input logic signed [7:0] b);
        max8 = (a > b) ? a : b;
    endfunction : max8

    function automatic logic signed [15:0] lowpass(input logic signed [15:0] acc,
                                                   input logic signed [7:0]  x,
                                                   input logic [3:0]         sh);
        logic signed [16:0] diff;
        diff    = 17'(signed'({x, {dat_pkg::FRAC_BITS{1'b0}}})) - 17'(acc);
        lowpass = 16'(17'(acc) + (diff >>> sh));
    endfunction : lowpass

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] clkSync_q;
    logic [1:0] selSync_q;
    logic [1:0] mosiSync_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clkSync_q  <= 3'h0;
            selSync_q  <= 2'h3;
            mosiSync_q <= 2'h0;
        end else begin
            clkSync_q  <= {clkSync_q[1:0], spiClk};
            selSync_q  <= {selSync_q[0], spiSelN};
            mosiSync_q <= {mosiSync_q[0], spiMosi};
        end
    end

    logic clkRise;
    logic clkFall;
    logic inFrame;
    assign clkRise = clkSync_q[1] & ~clkSync_q[2];
    assign clkFall = ~clkSync_q[1] & clkSync_q[2];
    assign inFrame = ~selSync_q[1];

    // ****************************************************************
    // serial port
    // ****************************************************************
    dat_pkg::dat_spi_state_t spiState_q, spiState_d;
    logic [4:0] bitCnt_q,  bitCnt_d;
    logic [7:0] rxShift_q, rxShift_d;
    logic [7:0] txShift_q, txShift_d;
    logic [6:0] addr_q,    addr_d;
    logic       isWrite_q, isWrite_d;
    logic       wrStb_q,   wrStb_d;
    logic [7:0] wrData_q,  wrData_d;
    logic       miso_q,    miso_d;
    logic       misoOe_q,  misoOe_d;
    logic [7:0] readData;

    always_comb begin
        spiState_d = spiState_q;
        bitCnt_d   = bitCnt_q;
        rxShift_d  = rxShift_q;
        txShift_d  = txShift_q;
        addr_d     = addr_q;
        isWrite_d  = isWrite_q;
        wrStb_d    = 1'b0;
        wrData_d   = wrData_q;
        miso_d     = miso_q;
        misoOe_d   = inFrame;
        if (!inFrame) begin
            spiState_d = dat_pkg::SPI_IDLE;
            bitCnt_d   = 5'h00;
            miso_d     = 1'b0;
        end else begin
            case (spiState_q)
                dat_pkg::SPI_IDLE: begin
                    spiState_d = dat_pkg::SPI_ADDR;
                    bitCnt_d   = 5'h00;
                end
                dat_pkg::SPI_ADDR: begin
                    if (clkRise) begin
                        rxShift_d = {rxShift_q[6:0], mosiSync_q[1]};
                        bitCnt_d  = bitCnt_q + 5'h01;
                        if (bitCnt_q == dat_pkg::ADDR_LAST_BIT) begin
                            isWrite_d  = rxShift_q[6];
                            addr_d     = {rxShift_q[5:0], mosiSync_q[1]};
                            spiState_d = dat_pkg::SPI_DATA;
                        end
                    end
                end
                dat_pkg::SPI_DATA: begin
                    if (clkFall) begin
                        miso_d    = txShift_q[7];
                        txShift_d = {txShift_q[6:0], 1'b0};
                    end
                    if (clkRise) begin
                        rxShift_d = {rxShift_q[6:0], mosiSync_q[1]};
                        bitCnt_d  = bitCnt_q + 5'h01;
                        if (bitCnt_q == dat_pkg::DATA_LAST_BIT) begin
                            wrStb_d    = isWrite_q;
                            wrData_d   = {rxShift_q[6:0], mosiSync_q[1]};
                            spiState_d = dat_pkg::SPI_ADDR;
                            bitCnt_d   = 5'h00;
                        end
                    end
                end
                default: spiState_d = dat_pkg::SPI_IDLE;
            endcase
        end
        if (spiState_q == dat_pkg::SPI_ADDR && spiState_d == dat_pkg::SPI_DATA) begin
            txShift_d = readData;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            spiState_q <= dat_pkg::SPI_IDLE;
            bitCnt_q   <= 5'h00;
            rxShift_q  <= 8'h00;
            txShift_q  <= 8'h00;
            addr_q     <= 7'h00;
            isWrite_q  <= 1'b0;
            wrStb_q    <= 1'b0;
            wrData_q   <= 8'h00;
            miso_q     <= 1'b0;
            misoOe_q   <= 1'b0;
        end else begin
            spiState_q <= spiState_d;
            bitCnt_q   <= bitCnt_d;
            rxShift_q  <= rxShift_d;
            txShift_q  <= txShift_d;
            addr_q     <= addr_d;
            isWrite_q  <= isWrite_d;
            wrStb_q    <= wrStb_d;
            wrData_q   <= wrData_d;
            miso_q     <= miso_d;
            misoOe_q   <= misoOe_d;
        end
    end

    assign spiMisoOut = miso_q;
    assign spiMisoOe  = misoOe_q;

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] gainCtrl_q, gainCtrl_d;
    logic [7:0] pfCfg_q,    pfCfg_d;
    logic [7:0] thrOne_q,   thrOne_d;
    logic [7:0] thrTwo_q,   thrTwo_d;
    logic [7:0] thrThree_q, thrThree_d;
    logic [7:0] fcOne_q,    fcOne_d;
    logic [7:0] fcTwo_q,    fcTwo_d;
    logic signed [7:0]  corr_q;
    logic signed [15:0] pf_q;

    always_comb begin
        gainCtrl_d = gainCtrl_q;
        pfCfg_d    = pfCfg_q;
        thrOne_d   = thrOne_q;
        thrTwo_d   = thrTwo_q;
        thrThree_d = thrThree_q;
        fcOne_d    = fcOne_q;
        fcTwo_d    = fcTwo_q;
        if (wrStb_q) begin
            case (addr_q)
                dat_pkg::OFS_GAIN_CTRL:  gainCtrl_d = wrData_q;
                dat_pkg::OFS_POSTFILTER: pfCfg_d    = wrData_q;
                dat_pkg::OFS_THR_ONE:    thrOne_d   = wrData_q;
                dat_pkg::OFS_THR_TWO:    thrTwo_d   = wrData_q;
                dat_pkg::OFS_THR_THREE:  thrThree_d = wrData_q;
                dat_pkg::OFS_FC_ONE:     fcOne_d    = wrData_q;
                dat_pkg::OFS_FC_TWO:     fcTwo_d    = wrData_q;
                default: ;  // readouts and holes ignore writes RULE_25
            endcase
        end
        case (addr_d)
            dat_pkg::OFS_GAIN_CTRL:  readData = gainCtrl_q;
            dat_pkg::OFS_POSTFILTER: readData = pfCfg_q;
            dat_pkg::OFS_THR_ONE:    readData = thrOne_q;
            dat_pkg::OFS_THR_TWO:    readData = thrTwo_q;
            dat_pkg::OFS_THR_THREE:  readData = thrThree_q;
            dat_pkg::OFS_FC_ONE:     readData = fcOne_q;
            dat_pkg::OFS_FC_TWO:     readData = fcTwo_q;
            dat_pkg::OFS_FREQ_ERR:   readData = corr_q;  // RULE_01
            dat_pkg::OFS_PF_SAMPLE:  readData = pf_q[15:8];
            default:                 readData = dat_pkg::ZERO_BYTE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gainCtrl_q <= dat_pkg::RST_GAIN_CTRL;
            pfCfg_q    <= dat_pkg::RST_POSTFILTER;
            thrOne_q   <= dat_pkg::RST_THR_ONE;
            thrTwo_q   <= dat_pkg::RST_THR_TWO;
            thrThree_q <= dat_pkg::RST_THR_THREE;
            fcOne_q    <= dat_pkg::RST_FC_ONE;
            fcTwo_q    <= dat_pkg::RST_FC_TWO;
        end else begin
            gainCtrl_q <= gainCtrl_d;
            pfCfg_q    <= pfCfg_d;
            thrOne_q   <= thrOne_d;
            thrTwo_q   <= thrTwo_d;
            thrThree_q <= thrThree_d;
            fcOne_q    <= fcOne_d;
            fcTwo_q    <= fcTwo_d;
        end
    end

    // field views
    logic [2:0] maxOffset;
    logic [1:0] loopGain;
    logic       freezeOnPre;
    logic       modFsk;
    logic [2:0] largeDiv;
    logic       pfBwSel;
    logic [4:0] peakTc;
    logic [1:0] dischTime;
    logic       thrBw;
    logic       thrType;
    logic signed [7:0] thrFloor;
    assign maxOffset   = fcOne_q[dat_pkg::MAX_OFS_LSB +: 3];
    assign loopGain    = fcOne_q[dat_pkg::LOOP_GAIN_LSB +: 2];
    assign freezeOnPre = fcTwo_q[dat_pkg::FREEZE_BIT];
    assign modFsk      = fcTwo_q[dat_pkg::MOD_SEL_BIT];
    assign largeDiv    = pfCfg_q[dat_pkg::LARGE_DIV_LSB +: 3];
    assign pfBwSel     = pfCfg_q[dat_pkg::PF_BW_BIT];
    assign peakTc      = thrTwo_q[dat_pkg::PEAK_TC_LSB +: 5];
    assign dischTime   = thrTwo_q[dat_pkg::DISCH_LSB +: 2];
    assign thrBw       = thrThree_q[dat_pkg::THR_BW_BIT];
    assign thrType     = thrThree_q[dat_pkg::THR_TYPE_BIT];
    assign thrFloor    = thrOne_q;

    // ****************************************************************
    // frequency correction loop
    // ****************************************************************
    logic              active_q,  active_d;
    logic              frozen_q,  frozen_d;
    logic signed [7:0] corr_d;

    always_comb begin
        logic signed [9:0] sum;
        logic signed [9:0] lim;
        sum      = 10'sh000;
        lim      = 10'sh000;
        active_d = hostRxActive | polledRxActive;
        frozen_d = frozen_q;
        corr_d   = corr_q;
        lim      = 10'($unsigned(maxOffset)) <<< dat_pkg::OFS_SCALE_SH;  // RULE_03
        if (!active_d) begin
            frozen_d = 1'b0;
        end else if (!active_q) begin
            corr_d   = 8'sh00;  // RULE_04
            frozen_d = 1'b0;
        end else begin
            if (preambleDetect && freezeOnPre && modFsk && hostRxActive) begin
                frozen_d = 1'b1;  // RULE_05 RULE_06
            end
            if (freqErrValid && !frozen_q) begin
                sum = 10'(corr_q) + (10'(signed'(freqErrSample))
                      >>> (dat_pkg::LOOP_GAIN_MAX - loopGain));  // RULE_02
                if (sum > lim) begin
                    sum = lim;
                end else if (sum < -lim) begin
                    sum = -lim;
                end
                corr_d = 8'(sum);
            end
        end
        if (maxOffset == 3'h0) begin
            corr_d = 8'sh00;  // RULE_24
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
            frozen_q <= 1'b0;
            corr_q   <= 8'sh00;
        end else begin
            active_q <= active_d;
            frozen_q <= frozen_d;
            corr_q   <= corr_d;
        end
    end

    assign freqCorrOut      = corr_q;
    assign correctionFrozen = frozen_q;

    // ****************************************************************
    // post-demodulation filter and decision threshold
    // ****************************************************************
    logic signed [15:0] pf_d;
    logic signed [15:0] lp_q, lp_d;
    logic signed [7:0]  peak_q, peak_d;
    logic [11:0]        dischCnt_q, dischCnt_d;
    logic               data_q, data_d;

    always_comb begin
        logic signed [7:0] thr;
        logic signed [8:0] mid;
        thr        = 8'sh00;
        mid        = 9'sh000;
        pf_d       = pf_q;
        lp_d       = lp_q;
        peak_d     = peak_q;
        dischCnt_d = dischCnt_q + 12'h001;
        if (demodValid) begin
            pf_d = lowpass(pf_q, signed'(demodSample),
                           4'(largeDiv) + 4'(!pfBwSel));  // RULE_11
            lp_d = lowpass(lp_q, pf_d[15:8],
                           4'(largeDiv) + 4'h2 - 4'(thrBw));  // RULE_17
            if ($signed(pf_d[15:8]) > peak_q) begin
                peak_d = pf_d[15:8];
            end
        end
        if (dischCnt_q >= ({7'h00, peakTc} << dischTime)) begin
            dischCnt_d = 12'h000;  // RULE_18 RULE_19
            if (peak_d > thrFloor) begin
                peak_d = peak_d - 8'sh01;
            end
        end
        if (active_d && !active_q) begin
            lp_d   = 16'({thrFloor, {dat_pkg::FRAC_BITS{1'b0}}});
            peak_d = thrFloor;
        end
        mid = (9'(peak_q) + 9'(thrFloor)) >>> 1;
        if (modFsk) begin
            thr = 8'sh00;  // RULE_14
        end else if (!thrType) begin
            thr = max8(thrFloor, lp_q[15:8]);  // RULE_15 RULE_21 RULE_23
        end else begin
            thr = max8(thrFloor, 8'(mid));  // RULE_15 RULE_21 RULE_23
        end
        data_d = ($signed(pf_q[15:8]) > thr);  // RULE_13
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pf_q       <= 16'sh0000;
            lp_q       <= 16'sh0000;
            peak_q     <= 8'sh00;
            dischCnt_q <= 12'h000;
            data_q     <= 1'b0;
        end else begin
            pf_q       <= pf_d;
            lp_q       <= lp_d;
            peak_q     <= peak_d;
            dischCnt_q <= dischCnt_d;
            data_q     <= data_d;
        end
    end

    assign dataOut = data_q;

endmodule : dat_demod_backend

`default_nettype wire

// >>> pkg/dat_pkg.sv
// dat_pkg: register map, field layout and constants of the demodulator back end
// assumes: 8-bit register words reached over a four-wire serial port
package dat_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [6:0] OFS_GAIN_CTRL  = 7'h01;
    localparam logic [6:0] OFS_POSTFILTER = 7'h03;
    localparam logic [6:0] OFS_THR_ONE    = 7'h04;
    localparam logic [6:0] OFS_THR_TWO    = 7'h05;
    localparam logic [6:0] OFS_THR_THREE  = 7'h06;
    localparam logic [6:0] OFS_FC_ONE     = 7'h07;
    localparam logic [6:0] OFS_FC_TWO     = 7'h08;
    localparam logic [6:0] OFS_FREQ_ERR   = 7'h11;
    localparam logic [6:0] OFS_PF_SAMPLE  = 7'h12;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_GAIN_CTRL  = 8'h02;
    localparam logic [7:0] RST_POSTFILTER = 8'h00;
    localparam logic [7:0] RST_THR_ONE    = 8'h00;
    localparam logic [7:0] RST_THR_TWO    = 8'h00;
    localparam logic [7:0] RST_THR_THREE  = 8'h00;
    localparam logic [7:0] RST_FC_ONE     = 8'h00;
    localparam logic [7:0] RST_FC_TWO     = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SMALL_DIV_LSB = 0;
    localparam int LARGE_DIV_LSB = 3;
    localparam int PF_BW_BIT     = 6;
    localparam int PEAK_TC_LSB   = 0;
    localparam int DISCH_LSB     = 5;
    localparam int THR_GAIN_LSB  = 0;
    localparam int THR_BW_BIT    = 5;
    localparam int THR_TYPE_BIT  = 6;
    localparam int MAX_OFS_LSB   = 0;
    localparam int LOOP_GAIN_LSB = 3;
    localparam int FREEZE_BIT    = 0;
    localparam int MOD_SEL_BIT   = 1;

    // ****************************************************************
    // arithmetic constants
    // ****************************************************************
    localparam int         FRAC_BITS     = 8;
    localparam int         OFS_SCALE_SH  = 4;
    localparam logic [1:0] LOOP_GAIN_MAX = 2'h3;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] DATA_LAST_BIT = 5'h0F;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_ADDR = 2'b01,
        SPI_DATA = 2'b10
    } dat_spi_state_t;
endpackage : dat_pkg

// >>> sim/dat_chk.sv
// dat_chk: port-level assertions for the demodulator back end
// assumes: bound to dat_demod_backend, everything on mclk
`timescale 1ns/1ns
`default_nettype none
module dat_chk (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // serial port
    input wire logic       spiSelN,
    input wire logic       spiMisoOut,
    input wire logic       spiMisoOe,
    // receiver and loop
    input wire logic       hostRxActive,
    input wire logic       polledRxActive,
    input wire logic       preambleDetect,
    input wire logic       freqErrValid,
    input wire logic [7:0] freqCorrOut,
    input wire logic       correctionFrozen
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire logic rxOn = hostRxActive || polledRxActive;
    // ****************************************************************
    // sequences
    // ****************************************************************
    sequence s_rx_start;
        !rxOn ##1 rxOn;
    endsequence
    sequence s_frozen_two;
        correctionFrozen ##1 correctionFrozen;
    endsequence
    a_corr_start: assert property (s_rx_start |=> freqCorrOut == 8'h00)
        else $error("correction not cleared at receive start");
    a_frozen_hold: assert property (s_frozen_two |-> $stable(freqCorrOut))
        else $error("correction moved while frozen");
    a_freeze_cause: assert property ($rose(correctionFrozen) |-> $past(preambleDetect)
        && $past(hostRxActive)) else $error("freeze without host preamble");
    a_frozen_stays: assert property (correctionFrozen && hostRxActive |=> correctionFrozen)
        else $error("freeze dropped during host receive");
    a_frozen_clear: assert property (!rxOn |=> !correctionFrozen)
        else $error("freeze kept outside receive");
    a_corr_cause: assert property ($changed(freqCorrOut) |-> $past(freqErrValid)
        || !$past(rxOn, 2)) else $error("correction changed without cause");
    a_corr_bound: assert property ($signed(freqCorrOut) <= 112
        && $signed(freqCorrOut) >= -112) else $error("correction beyond offset range");
    a_oe_off: assert property (spiSelN [*4] |-> !spiMisoOe)
        else $error("output enable while deselected");
    a_oe_on: assert property ($fell(spiSelN) |-> ##[2:5] spiMisoOe)
        else $error("output enable late after select");
    a_miso_idle: assert property (!spiMisoOe |-> !spiMisoOut)
        else $error("serial out active while disabled");
endmodule : dat_chk
bind dat_demod_backend dat_chk chk_u (.mclk(mclk), .rst(rst), .spiSelN(spiSelN),
    .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .hostRxActive(hostRxActive),
    .polledRxActive(polledRxActive), .preambleDetect(preambleDetect),
    .freqErrValid(freqErrValid), .freqCorrOut(freqCorrOut),
    .correctionFrozen(correctionFrozen));
`default_nettype wire

// >>> sim/dat_spi_host.sv
// dat_spi_host: serial port master standing in for the microcontroller
// assumes: 16-bit frames, command then data, MSB first, 125 ns clock
`timescale 1ns/1ns
`default_nettype none
module dat_spi_host (
    // serial pins toward the block
    output var  logic spiClk,
    output var  logic spiSelN,
    output var  logic spiMosi,
    input  wire logic spiMisoOut
);
    initial begin
        spiClk  = 1'b0;
        spiSelN = 1'b1;
        spiMosi = 1'b0;
    end
    // ****************************************************************
    // one frame; clock stands still between frames
    // ****************************************************************
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] w;
        w = {cmd, wd};
        spiSelN = 1'b0;
        #63;
        for (int i = 0; i < 16; i++) begin
            spiMosi = w[15-i];
            #62;
            if (i > 7) rd[15-i] = spiMisoOut;
            spiClk = 1'b1;
            #63;
            spiClk = 1'b0;
        end
        #63;
        spiMosi = ~spiMosi;  // released line shows the inverse of its last bit
        spiSelN = 1'b1;
        #200;
    endtask : xfer
endmodule : dat_spi_host
`default_nettype wire

// >>> sim/testbench.sv
// testbench: self-checking bench for dat_demod_backend
// assumes: dat_spi_host as register master, samples driven on mclk
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       mclk, rst, spiClk, spiSelN, spiMosi, spiMisoOut, spiMisoOe;
    logic       hostRxActive, polledRxActive, preambleDetect;
    logic       freqErrValid, demodValid, correctionFrozen, dataOut;
    logic [7:0] freqErrSample, demodSample, freqCorrOut, got;
    int         fails, compares;
    always #5 mclk = ~mclk;
    dat_spi_host host_u (.spiClk(spiClk), .spiSelN(spiSelN), .spiMosi(spiMosi),
        .spiMisoOut(spiMisoOut));
    dat_demod_backend dut_u (.mclk(mclk), .rst(rst), .spiClk(spiClk), .spiSelN(spiSelN),
        .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe),
        .hostRxActive(hostRxActive), .polledRxActive(polledRxActive),
        .preambleDetect(preambleDetect), .freqErrValid(freqErrValid),
        .freqErrSample(freqErrSample), .demodValid(demodValid), .demodSample(demodSample),
        .freqCorrOut(freqCorrOut), .correctionFrozen(correctionFrozen), .dataOut(dataOut));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk8
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b1, a}, d, got);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
        host_u.xfer({1'b0, a}, 8'h00, got);
        chk8(n, e, got);
    endtask : rd
    task automatic rx(input logic h, input logic p);
        tick(1);
        hostRxActive   = h;
        polledRxActive = p;
        tick(3);
    endtask : rx
    task automatic fe(input logic [7:0] v);
        tick(1);
        freqErrSample = v;
        freqErrValid  = 1'b1;
        tick(1);
        freqErrValid  = 1'b0;
    endtask : fe
    task automatic dm(input logic [7:0] v);
        tick(1);
        demodSample = v;
        demodValid  = 1'b1;
        tick(1);
        demodValid  = 1'b0;
        tick(3);
    endtask : dm
    task automatic pre;
        tick(1);
        preambleDetect = 1'b1;
        tick(1);
        preambleDetect = 1'b0;
    endtask : pre
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        rd(7'h01, 8'h02, "gain reset");
        for (int i = 3; i < 9; i++) rd(7'(i), 8'h00, "config reset");
        wr(7'h04, 8'h9C);
        rd(7'h04, 8'h9C, "floor readback");
        wr(7'h11, 8'h55);
        rd(7'h11, 8'h00, "error readout write");
        rd(7'h2A, 8'h00, "unmapped read");
        $display("test registers done");
    endtask : t_regs
    task automatic t_loop;
        wr(7'h07, 8'h19);
        wr(7'h08, 8'h03);
        rx(1'b1, 1'b0);
        repeat (3) fe(8'h0A);
        chk8("clamped correction", 8'h10, freqCorrOut);
        rd(7'h11, 8'h10, "error readout");
        pre();
        chk8("frozen flag", 8'h01, {7'h00, correctionFrozen});
        fe(8'hF6);
        chk8("held correction", 8'h10, freqCorrOut);
        rx(1'b0, 1'b0);
        rx(1'b0, 1'b1);
        chk8("restart correction", 8'h00, freqCorrOut);
        pre();
        repeat (3) fe(8'hF6);
        chk8("polled correction", 8'hF0, freqCorrOut);
        $display("test loop done");
    endtask : t_loop
    task automatic t_ask_off;
        rx(1'b0, 1'b0);
        wr(7'h08, 8'h01);
        rx(1'b1, 1'b0);
        pre();
        fe(8'h0A);
        chk8("ask freeze flag", 8'h00, {7'h00, correctionFrozen});
        chk8("ask correction", 8'h0A, freqCorrOut);
        rx(1'b0, 1'b0);
        rx(1'b1, 1'b0);
        wr(7'h07, 8'h18);
        fe(8'h0A);
        chk8("disabled correction", 8'h00, freqCorrOut);
        $display("test freeze and disable done");
    endtask : t_ask_off
    task automatic t_decide;
        wr(7'h08, 8'h02);
        wr(7'h03, 8'h40);
        dm(8'h14);
        chk8("fsk mark", 8'h01, {7'h00, dataOut});
        rd(7'h12, 8'h14, "full band sample");
        dm(8'hEC);
        chk8("fsk space", 8'h00, {7'h00, dataOut});
        wr(7'h03, 8'h00);
        dm(8'h14);
        rd(7'h12, 8'h00, "narrow band sample");
        wr(7'h12, 8'h7F);
        rd(7'h12, 8'h00, "sample write");
        wr(7'h08, 8'h00);
        wr(7'h06, 8'h4B);
        wr(7'h05, 8'h74);
        wr(7'h04, 8'h00);
        wr(7'h03, 8'h40);
        repeat (3) dm(8'h64);
        chk8("ask strong", 8'h01, {7'h00, dataOut});
        dm(8'h14);
        chk8("ask below peak", 8'h00, {7'h00, dataOut});
        wr(7'h06, 8'h0B);
        dm(8'h28);
        chk8("ask lowpass", 8'h01, {7'h00, dataOut});
        $display("test decision done");
    endtask : t_decide
    initial begin
        #900000;
        fails++;
        report_and_stop();
    end
    initial begin
        mclk = 1'b0;
        {hostRxActive, polledRxActive, preambleDetect, freqErrValid, demodValid} = 5'h00;
        {freqErrSample, demodSample, fails, compares} = '0;
        rst = 1'b1;
        tick(20);
        rst = 1'b0;
        tick(4);
        t_regs();
        t_loop();
        t_ask_off();
        t_decide();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
